// [shared/cfg_one_pkg.sv]
// Package: register map, field positions and decoded types for config register one
package cfg_one_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_NONVOL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_VOL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LEGACY = 4'hC;
  localparam int BIT_RSV_HI = 7;
  localparam int BIT_SPLIT = 6;
  localparam int BIT_EDGE = 5;
  localparam int BIT_PLOCK = 4;
  localparam int BIT_RSV_LO = 3;
  localparam int BIT_TOPBOT = 2;
  localparam int BIT_QUAD = 1;
  localparam int BIT_TLOCK = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] LEGACY_RESET = 3'h0;
  localparam logic [7:0] GUARDED_MASK = 8'h64;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SECT_LOW,
    SECT_HIGH,
    SECT_SPLIT
  } sector_place_t;

  typedef enum logic [1:0] {
    LOCK_OPEN,
    LOCK_PERMANENT,
    LOCK_UNTIL_POWER
  } lock_state_t;

  typedef struct packed {
    sector_place_t sector_place;
    logic protect_from_bottom;
    logic readable_low_range;
    lock_state_t lock_state;
    logic quad_data;
    logic wp_is_data_line_two;
    logic reset_is_data_line_three;
    logic addr_lines_four_ok;
  } cfg_decode_t;
endpackage

// [logic/flash_config_reg1_lock.sv]
// Config register one: nonvolatile and volatile copies, locks and decoded controls
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Overview of operation
// - Bit 6 split select groups small sectors together or splits high/low.
// - Split 0 with top/bottom 0 low, 1 high; split 1 divides both.
// - Top/bottom bit 2 picks highest or lowest large sector to replace.
// - Protection edge bit 5 makes legacy protect count from top or bottom.
// - Protection edge bit also picks readable range in read-password mode.
// - Permanent lock only sets in nonvolatile copy; blocks guarded bits until reset.
// - Temporary lock writable only in volatile copy; cleared at reset.
// - Lock decodes as open, permanent, or locked until next power-down.
// - Quad select bit 1 gives four-bit data, pins become data lines.
// - Quad mode: opcode one line, address one or four, data four.
// ****************************************************************
module flash_config_reg1_lock
  import cfg_one_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output cfg_decode_t decode_out
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] nonvol_q, nonvol_d;
  logic [7:0] vol_q, vol_d;
  logic [2:0] legacy_q, legacy_d;
  logic loaded_q, loaded_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic aw_have_q, aw_have_d;
  logic [7:0] wdata_q, wdata_d;
  logic w_have_q, w_have_d;
  logic w_lane_q, w_lane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  cfg_decode_t decode_q, decode_d;
  logic guarded_locked;
  logic do_write;
  // Channel transfer strobes
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic b_done;
  logic r_done;
  logic [7:0] vol_view;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_NONVOL) || (a == OFS_VOL) || (a == OFS_STATUS) || (a == OFS_LEGACY);
  endfunction

  // Merge write value into stored byte under a mask of writable bits
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                       input logic [7:0] wmask);
    merge = (old & ~wmask) | (val & wmask);
  endfunction

  // Software view of the volatile copy; only quad and temporary lock live there
  function automatic logic [7:0] vol_image(input logic [7:0] nv, input logic [7:0] v);
    vol_image = nv;
    vol_image[BIT_QUAD] = v[BIT_QUAD];
    vol_image[BIT_TLOCK] = v[BIT_TLOCK];
  endfunction

  assign s_axi_awready_out = !aw_have_q && !bvalid_q;
  assign s_axi_wready_out = !w_have_q && !bvalid_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign decode_out = decode_q;

  // Either lock freezes the guarded bits
  assign guarded_locked = nonvol_q[BIT_PLOCK] | vol_q[BIT_TLOCK];
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  // One item per edge with valid and ready both high
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign b_done = s_axi_bvalid_out && s_axi_bready_in;
  assign r_done = s_axi_rvalid_out && s_axi_rready_in;
  // Volatile guarded bits and permanent lock mirror the nonvolatile copy
  assign vol_view = vol_image(nonvol_q, vol_q);

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  always_comb begin
    logic [7:0] wmask;
    wmask = 8'h00;
    nonvol_d = nonvol_q;
    vol_d = vol_q;
    legacy_d = legacy_q;
    loaded_d = 1'b1;
    // Copy image after reset release; async reset can only load constants
    if (!loaded_q) begin
      vol_d = nonvol_q;
      vol_d[BIT_TLOCK] = 1'b0;
    end
    // Stores wait for the copy, else they would overwrite it
    if (do_write && w_lane_q && loaded_q) begin
      unique case (awaddr_q)
        OFS_NONVOL: begin
          // Quad always writable; guarded bits only while unlocked
          wmask[BIT_QUAD] = 1'b1;
          wmask = wmask | (guarded_locked ? 8'h00 : GUARDED_MASK);
          nonvol_d = merge(nonvol_q, wdata_q, wmask);
          // Permanent lock is set-only; temporary lock is read-only here
          nonvol_d[BIT_PLOCK] = nonvol_q[BIT_PLOCK] | wdata_q[BIT_PLOCK];
          nonvol_d[BIT_RSV_HI] = 1'b0;
          nonvol_d[BIT_RSV_LO] = 1'b0;
        end
        OFS_VOL: begin
          wmask[BIT_QUAD] = 1'b1;
          wmask[BIT_TLOCK] = 1'b1;
          vol_d = merge(vol_q, wdata_q, wmask);
        end
        OFS_LEGACY: begin
          if (!guarded_locked) begin
            legacy_d = wdata_q[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Nonvolatile copy modelled as reset to factory value
      nonvol_q <= CFG_RESET;
      vol_q <= CFG_RESET;
      legacy_q <= LEGACY_RESET;
      // Loaded flag drops so the copy runs again after each reset
      loaded_q <= 1'b0;
    end else begin
      nonvol_q <= nonvol_d;
      vol_q <= vol_d;
      legacy_q <= legacy_d;
      loaded_q <= loaded_d;
    end
  end

  // ****************************************************************
  // Write channel
  // ****************************************************************
  always_comb begin
    awaddr_d = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d = wdata_q;
    w_have_d = w_have_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (aw_take) begin
      awaddr_d = s_axi_awaddr_in;
      aw_have_d = 1'b1;
    end
    if (w_take) begin
      // Only byte lane zero carries register bits
      wdata_d = s_axi_wdata_in[7:0];
      w_lane_d = s_axi_wstrb_in[0];
      w_have_d = 1'b1;
    end
    // Response waits for both items, which may come in either order
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (b_done) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awaddr_q <= '0;
      aw_have_q <= 1'b0;
      wdata_q <= 8'h00;
      w_have_q <= 1'b0;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      awaddr_q <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q <= wdata_d;
      w_have_q <= w_have_d;
      w_lane_q <= w_lane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    // One read at a time: arready is low while an answer stands
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr_in)
        OFS_NONVOL: rdata_d = {24'h000000, nonvol_q};
        OFS_VOL: rdata_d = {24'h000000, vol_view};
        OFS_STATUS: rdata_d = {24'h000000, 4'h0, decode_q.lock_state,
                               decode_q.sector_place};
        OFS_LEGACY: rdata_d = {29'h00000000, legacy_q};
        default: rdata_d = 32'h00000000;
      endcase
    end else if (r_done) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  always_comb begin
    decode_d = '0;
    // Guarded bits live only in the nonvolatile copy
    if (nonvol_q[BIT_SPLIT]) begin
      decode_d.sector_place = SECT_SPLIT;
    end else if (nonvol_q[BIT_TOPBOT]) begin
      decode_d.sector_place = SECT_HIGH;
    end else begin
      decode_d.sector_place = SECT_LOW;
    end
    decode_d.protect_from_bottom = nonvol_q[BIT_EDGE];
    decode_d.readable_low_range = ~nonvol_q[BIT_EDGE];
    if (nonvol_q[BIT_PLOCK]) begin
      decode_d.lock_state = LOCK_PERMANENT;
    end else if (vol_q[BIT_TLOCK]) begin
      decode_d.lock_state = LOCK_UNTIL_POWER;
    end else begin
      decode_d.lock_state = LOCK_OPEN;
    end
    decode_d.quad_data = vol_q[BIT_QUAD];
    decode_d.wp_is_data_line_two = vol_q[BIT_QUAD];
    decode_d.reset_is_data_line_three = vol_q[BIT_QUAD];
    decode_d.addr_lines_four_ok = vol_q[BIT_QUAD];
  end

  // ****************************************************************
  // Decoded control register
  // ****************************************************************
  // Registered so decoded controls move only on a clock edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      decode_q <= '0;
    end else begin
      decode_q <= decode_d;
    end
  end

endmodule
`default_nettype wire

// [bench/cfg_one_chk.sv]
// Checker for config register one bus and decode
`timescale 1ns/1ps
`default_nettype none
module cfg_one_chk
  import cfg_one_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire cfg_decode_t decode_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ar;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  property p_rlat; s_ar |=> s_axi_rvalid_out; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_bhold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bdone; s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated");
  property p_bref; s_axi_bvalid_out |-> !s_axi_awready_out; endproperty
  a_bref: assert property (p_bref) else $error("address taken during answer");
  property p_rref; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
  a_rref: assert property (p_rref) else $error("read taken during answer");
  // Permanent lock can never fall back without a reset
  property p_plock;
    decode_out.lock_state == LOCK_PERMANENT |=> decode_out.lock_state == LOCK_PERMANENT;
  endproperty
  a_plock: assert property (p_plock) else $error("permanent lock lost");
  property p_quad;
    decode_out.wp_is_data_line_two == decode_out.quad_data
      && decode_out.reset_is_data_line_three == decode_out.quad_data;
  endproperty
  a_quad: assert property (p_quad) else $error("pin roles differ from width");
endmodule
bind flash_config_reg1_lock cfg_one_chk i_cfg_one_chk (.*);
`default_nettype wire

// [bench/cfg_host_model.sv]
// Host model: bus master for config register one
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
  import cfg_one_pkg::*;
(
  input wire logic clk_in,
  output logic [ADDR_W-1:0] s_axi_awaddr_in,
  output logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  output logic [31:0] s_axi_wdata_in,
  output logic [3:0] s_axi_wstrb_in,
  output logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  output logic s_axi_bready_in,
  output logic [ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  output logic s_axi_rready_in
);
  int stall = 0;
  initial begin
    {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
    {s_axi_wvalid_in, s_axi_bready_in, s_axi_araddr_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in} = '0;
  end
  // Ready is sampled at the falling edge, where it holds for the next rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, b;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= 4'hF;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    // Bready stays high after the answer; each write sets it high again
    s_axi_bready_in <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk_in);
      ta = s_axi_awvalid_in && s_axi_awready_out;
      tw = s_axi_wvalid_in && s_axi_wready_out;
      b = s_axi_bvalid_out;
      @(posedge clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
    end
  endtask
  // Only this register set is read; status two is never polled
  task automatic rd(input logic [3:0] a);
    logic ta, r;
    int n;
    n = stall;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk_in);
      ta = s_axi_arvalid_in && s_axi_arready_out;
      r = s_axi_rvalid_out && s_axi_rready_in;
      @(posedge clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
      if (n > 0) n--;
      else s_axi_rready_in <= !r;
    end
  endtask
endmodule
`default_nettype wire

// [bench/flash_config_reg1_lock_tb_top.sv]
// Testbench for config register one
`timescale 1ns/1ps
`default_nettype none
module flash_config_reg1_lock_tb_top
  import cfg_one_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in;
  cfg_decode_t decode_out;
  logic [33:0] exp_q[$];
  logic [7:0] pv[4] = '{8'h00, 8'h04, 8'h40, 8'h44};
  logic [31:0] seed = 32'h11;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  always #2.5 clk_in = ~clk_in;
  flash_config_reg1_lock i_flash_config_reg1_lock (.*);
  cfg_host_model i_cfg_host_model (.*);
  // ****************************************
  // Tasks and monitor
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic w(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    seed = xs(seed);
    exp_q.push_back({r, 32'h0});
    i_cfg_host_model.wr(a, {seed[31:8], d});
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 24'h0, d});
    i_cfg_host_model.rd(a);
  endtask
  task automatic dk(input cfg_decode_t e);
    @(negedge clk_in);
    checks++;
    if (decode_out !== e) begin
      $display("ERROR decode_out expected %h seen %h", e, decode_out);
      bad_count++;
    end
    @(posedge clk_in);
  endtask
  task automatic end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(negedge clk_in) begin
    logic [33:0] e, got;
    if ((s_axi_bvalid_out && s_axi_bready_in) || (s_axi_rvalid_out && s_axi_rready_in)) begin
      e = exp_q.pop_front();
      got = s_axi_rvalid_out ? {s_axi_rresp_out, s_axi_rdata_out} : {s_axi_bresp_out, 32'h0};
      checks++;
      if (got !== e) begin
        $display("ERROR bus answer expected %h seen %h", e, got);
        bad_count++;
      end
    end
  end
  // Ceiling well above the roughly 130 cycles the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rc(OFS_NONVOL, 8'h00, RESP_OKAY);
    rc(OFS_VOL, 8'h00, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      w(OFS_NONVOL, pv[i], RESP_OKAY);
      rc(OFS_NONVOL, pv[i], RESP_OKAY);
      rc(OFS_STATUS, 8'((i < 2) ? i : 2), RESP_OKAY);
    end
    w(OFS_VOL, 8'h03, RESP_OKAY);
    rc(OFS_VOL, 8'h47, RESP_OKAY);
    rc(OFS_STATUS, 8'h0A, RESP_OKAY);
    dk('{SECT_SPLIT, 1'b0, 1'b1, LOCK_UNTIL_POWER, 1'b1, 1'b1, 1'b1, 1'b1});
    w(OFS_NONVOL, 8'h20, RESP_OKAY);
    rc(OFS_NONVOL, 8'h44, RESP_OKAY);
    w(OFS_LEGACY, 8'h07, RESP_OKAY);
    rc(OFS_LEGACY, 8'h00, RESP_OKAY);
    w(OFS_VOL, 8'h02, RESP_OKAY);
    // Guarded bits set in the same write as the permanent lock; reserved bits kept zero
    w(OFS_NONVOL, 8'h30, RESP_OKAY);
    rc(OFS_NONVOL, 8'h30, RESP_OKAY);
    rc(OFS_STATUS, 8'h04, RESP_OKAY);
    dk('{SECT_LOW, 1'b1, 1'b0, LOCK_PERMANENT, 1'b1, 1'b1, 1'b1, 1'b1});
    w(OFS_NONVOL, 8'h46, RESP_OKAY);
    rc(OFS_NONVOL, 8'h32, RESP_OKAY);
    w(OFS_NONVOL, 8'h00, RESP_OKAY);
    i_cfg_host_model.stall = 3;
    rc(OFS_NONVOL, 8'h30, RESP_OKAY);
    i_cfg_host_model.stall = 0;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = seed[7:0] & 8'h77;
      w(OFS_VOL, d, RESP_OKAY);
      rc(OFS_VOL, {6'h0C, d[1:0]}, RESP_OKAY);
    end
    rc(4'h2, 8'h00, RESP_SLVERR);
    w(4'h6, 8'h01, RESP_SLVERR);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rc(OFS_VOL, 8'h00, RESP_OKAY);
    dk('{SECT_LOW, 1'b0, 1'b1, LOCK_OPEN, 1'b0, 1'b0, 1'b0, 1'b0});
    end_of_test();
  end
endmodule
`default_nettype wire
